// File: pkg/eih_cfg.svh
`ifndef EIH_CFG_SVH
`define EIH_CFG_SVH
`define EIH_RING_NREG       3
`define EIH_SVC_NREG        5
`define EIH_REG_W           8
`define EIH_CWI_BIT         3
`define EIH_ZERO8           8'h00
`define EIH_RING_SEL_W      2
`define EIH_SVC_SEL_W       3
`define EIH_STATE_ATTENTION_IDX        3'h0
`define EIH_ESR_IDX         2'h0
`define EIH_SVC_PROBE       3'h1
`define EIH_RING_PROBE      2'h1
`define EIH_PROBE_LSB       8
`define EIH_MAR_PROBE       6
`endif

// File: pkg/eih_pkg.sv
package eih_pkg;
    typedef logic [7:0] eih_byte_t;
endpackage : eih_pkg

// File: verilog/eih_event_hier.sv
// Overview of operation
// - two active-low interrupt outputs: ring engine group and system-interface group
// - master attention bit is one when attention and its notify bits are both one
// - system-interface interrupt asserts when a master attention bit and master notify bit are one
// - attention bits update only where compare bit equals the present bit
// - reading an event register copies the value into the group compare register
// - one compare register per group, shared by every event register in it
// - master attention is derived, never written directly
// - ring condition register always shows merged masked latch outputs
// - latched condition clears only by writing its latch bit to zero
// - unchanged bits take write data, changed bits keep their value
// - blocked change sets write-inhibit in exception or state attention register
`include "eih_cfg.svh"
module eih_event_hier
    import eih_pkg::*;
#(
    parameter int RING_N = `EIH_RING_NREG,
    parameter int SVC_N  = `EIH_SVC_NREG
) (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire logic [RING_N*8-1:0]       ring_event,
    input  wire logic [SVC_N*8-1:0]        service_event,
    input  wire logic [RING_N*8-1:0]       ring_mask,
    input  wire logic [SVC_N*8-1:0]        service_notify,
    input  wire logic [7:0]                master_notify,
    input  wire logic                      ring_rd,
    input  wire logic                      ring_wr,
    input  wire logic [`EIH_RING_SEL_W-1:0] ring_sel,
    input  wire logic                      service_rd,
    input  wire logic                      service_wr,
    input  wire logic [`EIH_SVC_SEL_W-1:0]  service_sel,
    input  wire logic                      ring_cmp_wr,
    input  wire logic                      service_cmp_wr,
    input  wire logic [7:0]                wr_data,
    output logic      [7:0]                ring_rd_data,
    output logic      [7:0]                service_rd_data,
    output logic      [7:0]                ring_compare_reg,
    output logic      [7:0]                service_compare_reg,
    output logic      [7:0]                irq_condition_reg,
    output logic      [7:0]                master_attention,
    output logic                           ring_irq_n,
    output logic                           service_irq_n
);
    eih_byte_t ring_q [RING_N];
    eih_byte_t ring_d [RING_N];
    eih_byte_t svc_q  [SVC_N];
    eih_byte_t svc_d  [SVC_N];
    eih_byte_t rcmp_q, rcmp_d, scmp_q, scmp_d;
    eih_byte_t rrd_q, rrd_d, srd_q, srd_d;
    eih_byte_t icr_c, mar_c;

    // masked conditional write: new value only where compare matches present
    function automatic eih_byte_t cond_wr(eih_byte_t cur, eih_byte_t cmp, eih_byte_t wd);
        return (cur & ~(cur ^ cmp) & wd) | (cur & (cur ^ cmp)) | (~cur & ~(cur ^ cmp) & wd);
    endfunction : cond_wr

    // blocked-change detection: changed bit that the write tried to alter
    function automatic logic cond_blk(eih_byte_t cur, eih_byte_t cmp, eih_byte_t wd);
        return |((cur ^ cmp) & (cur ^ wd));
    endfunction : cond_blk

    always_comb begin
        icr_c = `EIH_ZERO8;
        for (int i = 0; i < RING_N; i++) begin
            icr_c[i] = |(ring_q[i] & ring_mask[i*`EIH_REG_W +: `EIH_REG_W]);
        end
        mar_c = `EIH_ZERO8;
        for (int i = 0; i < SVC_N; i++) begin
            mar_c[`EIH_REG_W-1-i] =
                |(svc_q[i] & service_notify[i*`EIH_REG_W +: `EIH_REG_W]);
        end
    end

    always_comb begin
        for (int i = 0; i < RING_N; i++) begin
            ring_d[i] = ring_q[i];
            if (ring_wr && ring_sel == i[`EIH_RING_SEL_W-1:0]) begin
                ring_d[i] = cond_wr(ring_q[i], rcmp_q, wr_data);
            end
            ring_d[i] = ring_d[i] | ring_event[i*`EIH_REG_W +: `EIH_REG_W];
        end
        if (ring_wr && cond_blk(ring_q[ring_sel], rcmp_q, wr_data)) begin
            ring_d[`EIH_ESR_IDX][`EIH_CWI_BIT] = 1'b1;
        end
        rcmp_d = rcmp_q;
        rrd_d  = rrd_q;
        if (ring_cmp_wr) begin
            rcmp_d = wr_data;
        end
        if (ring_rd) begin
            rrd_d  = ring_q[ring_sel];
            rcmp_d = ring_q[ring_sel];
        end
    end

    always_comb begin
        for (int i = 0; i < SVC_N; i++) begin
            svc_d[i] = svc_q[i];
            if (service_wr && service_sel == i[`EIH_SVC_SEL_W-1:0]) begin
                svc_d[i] = cond_wr(svc_q[i], scmp_q, wr_data);
            end
            svc_d[i] = svc_d[i] | service_event[i*`EIH_REG_W +: `EIH_REG_W];
        end
        if (service_wr && cond_blk(svc_q[service_sel], scmp_q, wr_data)) begin
            svc_d[`EIH_STATE_ATTENTION_IDX][`EIH_CWI_BIT] = 1'b1;
        end
        scmp_d = scmp_q;
        srd_d  = srd_q;
        if (service_cmp_wr) begin
            scmp_d = wr_data;
        end
        if (service_rd) begin
            srd_d  = svc_q[service_sel];
            scmp_d = svc_q[service_sel];
        end
    end

    // ring group registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < RING_N; i++) begin
                ring_q[i] <= `EIH_ZERO8;
            end
            rcmp_q <= `EIH_ZERO8;
            rrd_q  <= `EIH_ZERO8;
        end else begin
            ring_q <= ring_d;
            rcmp_q <= rcmp_d;
            rrd_q  <= rrd_d;
        end
    end

    // service group registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < SVC_N; i++) begin
                svc_q[i] <= `EIH_ZERO8;
            end
            scmp_q <= `EIH_ZERO8;
            srd_q  <= `EIH_ZERO8;
        end else begin
            svc_q  <= svc_d;
            scmp_q <= scmp_d;
            srd_q  <= srd_d;
        end
    end

    assign ring_rd_data        = rrd_q;
    assign service_rd_data     = srd_q;
    assign ring_compare_reg    = rcmp_q;
    assign service_compare_reg = scmp_q;
    assign irq_condition_reg   = icr_c;
    assign master_attention    = mar_c;
    assign ring_irq_n          = ~(|icr_c);
    assign service_irq_n       = ~(|(mar_c & master_notify));

    // access patterns used by the checks
    sequence s_ring_blocked_wr;
        ring_wr && cond_blk(ring_q[ring_sel], rcmp_q, wr_data);
    endsequence

    sequence s_svc_blocked_wr;
        service_wr && cond_blk(svc_q[service_sel], scmp_q, wr_data);
    endsequence

    sequence s_ring_quiet;
        !ring_wr && (ring_event == '0);
    endsequence

    sequence s_svc_quiet;
        !service_wr && (service_event == '0);
    endsequence

    sequence s_ring_cmp_idle;
        !ring_rd && !ring_cmp_wr;
    endsequence

    sequence s_svc_cmp_idle;
        !service_rd && !service_cmp_wr;
    endsequence

    a_ring_cmp_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        ring_rd |=> ring_compare_reg == $past(ring_q[ring_sel]))
        else $error("ring compare not loaded on read");
    a_svc_cmp_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        service_rd |=> service_compare_reg == $past(svc_q[service_sel]))
        else $error("service compare not loaded on read");
    a_svc_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
        service_irq_n == !(|(master_attention & master_notify)))
        else $error("service interrupt level wrong");
    a_ring_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
        ring_irq_n == (irq_condition_reg == `EIH_ZERO8))
        else $error("ring interrupt level wrong");
    a_svc_cwi_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_svc_blocked_wr |=> svc_q[`EIH_STATE_ATTENTION_IDX][`EIH_CWI_BIT])
        else $error("service write inhibit not set");
    a_ring_cwi_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_ring_blocked_wr |=> ring_q[`EIH_ESR_IDX][`EIH_CWI_BIT])
        else $error("ring write inhibit not set");
    a_ring_hold_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!ring_wr && ring_event == '0) |=> ring_q[0] == $past(ring_q[0]))
        else $error("ring latch changed without write");
    a_svc_match_wr: assert property (@(posedge core_clk) disable iff (sys_rst)
        (service_wr && service_sel == `EIH_SVC_PROBE && svc_q[`EIH_SVC_PROBE] == scmp_q
        && service_event == '0) |=> svc_q[`EIH_SVC_PROBE] == $past(wr_data))
        else $error("matching write not stored");

    a_ring_rd_data: assert property (@(posedge core_clk) disable iff (sys_rst)
        ring_rd
        |=> ring_rd_data == $past(ring_q[ring_sel]))
        else $error("ring read data not captured");

    a_svc_rd_data: assert property (@(posedge core_clk) disable iff (sys_rst)
        service_rd
        |=> service_rd_data == $past(svc_q[service_sel]))
        else $error("service read data not captured");

    a_ring_rd_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ring_rd
        |=> $stable(ring_rd_data))
        else $error("ring read data moved without read");

    a_svc_rd_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !service_rd
        |=> $stable(service_rd_data))
        else $error("service read data moved without read");

    a_ring_cmp_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_ring_cmp_idle
        |=> $stable(ring_compare_reg))
        else $error("ring compare moved without access");

    a_svc_cmp_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_svc_cmp_idle
        |=> $stable(service_compare_reg))
        else $error("service compare moved without access");

    a_ring_cmp_direct: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ring_cmp_wr && !ring_rd)
        |=> ring_compare_reg == $past(wr_data))
        else $error("ring compare not loaded by write");

    a_svc_cmp_direct: assert property (@(posedge core_clk) disable iff (sys_rst)
        (service_cmp_wr && !service_rd)
        |=> service_compare_reg == $past(wr_data))
        else $error("service compare not loaded by write");

    a_ring_probe_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_ring_quiet
        |=> $stable(ring_q[`EIH_RING_PROBE]))
        else $error("ring latch changed while quiet");

    a_svc_probe_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_svc_quiet
        |=> $stable(svc_q[`EIH_SVC_PROBE]))
        else $error("service attention changed while quiet");

    a_svc_state_attention_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_svc_quiet
        |=> $stable(svc_q[`EIH_STATE_ATTENTION_IDX]))
        else $error("state attention changed while quiet");

    a_ring_match_wr: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ring_wr && ring_sel == `EIH_RING_PROBE && ring_q[`EIH_RING_PROBE] == rcmp_q
        && ring_event == '0) |=> ring_q[`EIH_RING_PROBE] == $past(wr_data))
        else $error("ring matching write not stored");

    a_ring_blk_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ring_wr && ring_sel == `EIH_RING_PROBE && ring_event == '0)
        |=> ((ring_q[`EIH_RING_PROBE] ^ $past(ring_q[`EIH_RING_PROBE]))
        & ($past(ring_q[`EIH_RING_PROBE]) ^ $past(rcmp_q))) == '0)
        else $error("ring changed bit was overwritten");

    a_svc_blk_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (service_wr && service_sel == `EIH_SVC_PROBE && service_event == '0)
        |=> ((svc_q[`EIH_SVC_PROBE] ^ $past(svc_q[`EIH_SVC_PROBE]))
        & ($past(svc_q[`EIH_SVC_PROBE]) ^ $past(scmp_q))) == '0)
        else $error("service changed bit was overwritten");

    a_ring_event_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        ring_event[`EIH_PROBE_LSB +: `EIH_REG_W] != '0
        |=> (ring_q[`EIH_RING_PROBE] & $past(ring_event[`EIH_PROBE_LSB +: `EIH_REG_W]))
        == $past(ring_event[`EIH_PROBE_LSB +: `EIH_REG_W]))
        else $error("ring event not latched");

    a_svc_event_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        service_event[`EIH_PROBE_LSB +: `EIH_REG_W] != '0
        |=> (svc_q[`EIH_SVC_PROBE] & $past(service_event[`EIH_PROBE_LSB +: `EIH_REG_W]))
        == $past(service_event[`EIH_PROBE_LSB +: `EIH_REG_W]))
        else $error("service event not latched");

    a_mar_probe: assert property (@(posedge core_clk) disable iff (sys_rst)
        master_attention[`EIH_MAR_PROBE]
        == |(svc_q[`EIH_SVC_PROBE] & service_notify[`EIH_PROBE_LSB +: `EIH_REG_W]))
        else $error("master attention bit wrong");

    a_mar_no_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_svc_quiet ##1 $stable(service_notify)
        |-> $stable(master_attention))
        else $error("master attention moved on its own");

    a_icr_probe: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_condition_reg[`EIH_RING_PROBE]
        == |(ring_q[`EIH_RING_PROBE] & ring_mask[`EIH_PROBE_LSB +: `EIH_REG_W]))
        else $error("condition bit does not merge latch");

    a_svc_irq_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        master_notify == '0
        |-> service_irq_n)
        else $error("service interrupt with no master notify");

    a_ring_irq_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        ring_mask == '0
        |-> ring_irq_n)
        else $error("ring interrupt with all masks off");

    a_ring_cwi_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ring_q[`EIH_ESR_IDX][`EIH_CWI_BIT] && !(ring_wr && ring_sel == `EIH_ESR_IDX))
        |=> ring_q[`EIH_ESR_IDX][`EIH_CWI_BIT])
        else $error("ring write inhibit lost");

    a_svc_cwi_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (svc_q[`EIH_STATE_ATTENTION_IDX][`EIH_CWI_BIT] && !(service_wr && service_sel == `EIH_STATE_ATTENTION_IDX))
        |=> svc_q[`EIH_STATE_ATTENTION_IDX][`EIH_CWI_BIT])
        else $error("service write inhibit lost");
endmodule : eih_event_hier

// File: verification/tb_eih_event_hier.sv
module tb_eih_event_hier
    import eih_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, sys_rst, ring_rd, ring_wr, service_rd, service_wr;
    logic        ring_cmp_wr, service_cmp_wr, ring_irq_n, service_irq_n;
    logic [23:0] ring_event, ring_mask;
    logic [39:0] service_event, service_notify;
    logic [7:0]  master_notify, wr_data;
    logic [1:0]  ring_sel;
    logic [2:0]  service_sel;
    eih_byte_t   ring_rd_data, service_rd_data, ring_compare_reg, service_compare_reg;
    eih_byte_t   irq_condition_reg, master_attention;
    int          n_mismatch, comparisons;

    eih_event_hier #(.RING_N(3), .SVC_N(5)) u_eih_event_hier (
        .core_clk, .sys_rst, .ring_event, .service_event, .ring_mask, .service_notify,
        .master_notify, .ring_rd, .ring_wr, .ring_sel, .service_rd, .service_wr,
        .service_sel, .ring_cmp_wr, .service_cmp_wr, .wr_data, .ring_rd_data,
        .service_rd_data, .ring_compare_reg, .service_compare_reg, .irq_condition_reg,
        .master_attention, .ring_irq_n, .service_irq_n);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic tick;
        @(posedge core_clk);
        #2;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // one access strobe, then an idle edge
    task automatic acc(input logic svc, rd, wr, input logic [2:0] sel, input logic [7:0] d);
        if (svc) {service_rd, service_wr, service_sel} = {rd, wr, sel};
        else {ring_rd, ring_wr, ring_sel} = {rd, wr, sel[1:0]};
        wr_data = d;
        tick();
        {ring_rd, ring_wr, service_rd, service_wr} = 4'h0;
        tick();
    endtask : acc
    task automatic t_master;
        {service_notify[15:8], master_notify, service_event[8]} = 17'h00281;
        tick();
        service_event[8] = 1'b0;
        tick();
        check(master_attention, 8'h40);
        check({6'h00, ring_irq_n, service_irq_n}, 8'h02);
        master_notify = 8'h00;
        tick();
        check({6'h00, ring_irq_n, service_irq_n}, 8'h03);
        {master_notify, service_notify[15:8]} = 16'h4000;
        tick();
        check(master_attention, 8'h00);
        service_notify[15:8] = 8'h01;
        acc(1'b1, 1'b1, 1'b0, 3'h1, 8'h00);
        check(service_rd_data, 8'h01);
        check(ring_compare_reg, 8'h00);
        check({6'h00, ring_irq_n, service_irq_n}, 8'h02);
        acc(1'b1, 1'b0, 1'b1, 3'h1, 8'h00);
        check({master_attention[6], 5'h00, ring_irq_n, service_irq_n}, 8'h03);
    endtask : t_master
    task automatic t_ring;
        {ring_mask[15:8], ring_event[8]} = 9'h1ff;
        tick();
        ring_event[8] = 1'b0;
        tick();
        check(irq_condition_reg, 8'h02);
        check({6'h00, ring_irq_n, service_irq_n}, 8'h01);
        acc(1'b0, 1'b1, 1'b0, 3'h1, 8'h00);
        check(ring_compare_reg, 8'h01);
        ring_event[10] = 1'b1;
        tick();
        ring_event[10] = 1'b0;
        acc(1'b0, 1'b0, 1'b1, 3'h1, 8'h00);
        acc(1'b0, 1'b1, 1'b0, 3'h1, 8'h00);
        check(ring_rd_data, 8'h04);
        acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
        check(ring_rd_data, 8'h08);
        {ring_cmp_wr, wr_data} = 9'h104;
        tick();
        ring_cmp_wr = 1'b0;
        tick();
        check(ring_compare_reg, 8'h04);
        acc(1'b0, 1'b0, 1'b1, 3'h1, 8'h00);
        check(irq_condition_reg, 8'h00);
        check({6'h00, ring_irq_n, service_irq_n}, 8'h03);
    endtask : t_ring
    task automatic t_service;
        {service_cmp_wr, wr_data} = 9'h100;
        tick();
        {service_cmp_wr, service_event[16]} = 2'h1;
        tick();
        service_event[16] = 1'b0;
        acc(1'b1, 1'b0, 1'b1, 3'h2, 8'h00);
        acc(1'b1, 1'b1, 1'b0, 3'h2, 8'h00);
        check(service_rd_data, 8'h01);
        acc(1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
        check(service_rd_data, 8'h08);
        check(service_compare_reg, 8'h08);
    endtask : t_service
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {sys_rst, ring_rd, ring_wr, service_rd, service_wr, ring_cmp_wr, service_cmp_wr} = 7'h40;
        {ring_event, ring_mask, service_event, service_notify} = '0;
        {master_notify, wr_data, ring_sel, service_sel} = '0;
        repeat (4) @(posedge core_clk);
        #2 sys_rst = 1'b0;
        tick();
        check({master_attention[7:2], ring_irq_n, service_irq_n}, 8'h03);
        t_master();
        t_ring();
        t_service();
        summarize();
    end
endmodule : tb_eih_event_hier
